// File: fbm_bridge_model.sv
// partner model: bridge fets, bootstrap caps and flag pull-ups
`timescale 1ns/10ps
module fbm_bridge_model (
  input  wire logic       clk,
  input  wire logic [1:0] gate_hs,
  input  wire logic [1:0] gate_ls,
  input  wire logic [1:0] short_hs,
  input  wire logic [1:0] short_ls,
  input  wire logic [1:0] cap_bad,
  input  wire logic       f1_o,
  input  wire logic       f1_oe_n,
  input  wire logic       f2_o,
  input  wire logic       f2_oe_n,
  output logic [1:0]      boot_ok,
  output logic [1:0]      boot_low,
  output logic [1:0]      vds_hs,
  output logic [1:0]      vds_ls,
  output logic            f1_pin,
  output logic            f2_pin
);
  logic [7:0] chg [2] = '{8'h00, 8'h00};
  // pull-ups: a released flag reads high
  assign f1_pin = f1_oe_n ? 1'b1 : f1_o;
  assign f2_pin = f2_oe_n ? 1'b1 : f2_o;
  // an off fet carries full voltage, so its comparator trips; unkind on purpose
  assign vds_hs = ~gate_hs | short_hs;
  assign vds_ls = ~gate_ls | short_ls;
  assign boot_ok = {chg[1] >= 8'h14, chg[0] >= 8'h14};
  assign boot_low = {chg[1] < 8'h0a, chg[0] < 8'h0a};
  // caps charge only through the low side; a bad cap never holds charge
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (cap_bad[p]) chg[p] <= 8'h00;
      else if (gate_ls[p] && chg[p] < 8'h28) chg[p] <= chg[p] + 8'h01;
    end
  end
endmodule : fbm_bridge_model

// File: fbm_consts.svh
// timing counts, register offsets and reset values of the bridge fault monitor
`ifndef FBM_CONSTS_SVH
`define FBM_CONSTS_SVH
`define FBM_CLK_NS 5
`define FBM_BLANK_EXTRA_NS 600
`define FBM_BLANK_EXTRA_CYC ((`FBM_BLANK_EXTRA_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_BOOT_TMO_NS 10000
`define FBM_BOOT_TMO_CYC (`FBM_BOOT_TMO_NS / `FBM_CLK_NS)
`define FBM_RES_LIMIT_NS 10000
`define FBM_RES_LIMIT_CYC (`FBM_RES_LIMIT_NS / `FBM_CLK_NS)
`define FBM_ADDR_W 8
`define FBM_ADDR_CTRL 8'h00
`define FBM_ADDR_DEAD 8'h04
`define FBM_ADDR_STAT 8'h08
`define FBM_CTRL_EN_BIT 0
`define FBM_DEAD_W 12
`define FBM_DEAD_RST 12'h028
`define FBM_CTRL_RST 1'b1
`define FBM_SUP_RST 7'h34
`define FBM_PH_RST 12'h000
`endif

// File: fbm_fault_monitor.sv
// bridge fault monitor top: flags, latched faults, gate disable, ahb-lite registers
//
// Overview of operation
// RL1: two open-drain flags encode the fault class; both low means no fault.
// RL2: with several faults, each flag is the OR of all fault patterns.
// RL3: a disabling fault forces every gate drive low.
// RL4: overtemperature raises flag one only, not latched, no disable.
// RL5: the host must limit dissipation itself when overtemperature is flagged.
// RL6: gate supply undervoltage raises both flags, disables, clears unlatched.
// RL7: gate supply undervoltage holds from power-up until supply is good.
// RL8: low bootstrap before high side runs a low-side charge cycle first.
// RL9: high side on with sagging bootstrap starts a new charge cycle.
// RL10: charge timeout raises both flags, disables, latches until reset pin low.
// RL11: logic supply undervoltage raises both flags, disables, clears other faults.
// RL12: logic supply undervoltage holds from power-up until supply is good.
// RL13: comparator ignored while fet off and during post turn-on blanking.
// RL14: after blanking, excess drain-source voltage latches a disabling short.
// RL15: short detect disable suppresses short detection and its flag.
// RL16: low-side comparators detect phase short to supply, flag two.
// RL17: high-side comparators detect phase short to ground, flag two.
// RL18: shorted winding appears via the same detectors, flag two.
// RL19: a short low reset pulse clears latched disabling faults.
// RL20: a sustained low reset enters sleep and clears latched faults.
// RL21: blanking equals dead time plus a 600 ns comparator allowance.
// RL22: comparator, supply and temperature inputs are synchronised first.
// RL23: a raised flag releases its pin; a cleared flag pulls it low.
`timescale 1ns/10ps
`include "fbm_consts.svh"
module fbm_fault_monitor (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic [31:0]                    hrdata,
  output logic                           hresp,
  input  wire fbm_pkg::fbm_ph_in_t [1:0] phase_pins,
  input  wire logic                      over_temp,
  input  wire logic                      gate_supply_uv,
  input  wire logic                      logic_supply_uv,
  input  wire logic                      short_threshold_input,
  input  wire logic                      reset_pin_n,
  input  wire logic                      fault_flag_one_i,
  input  wire logic                      fault_flag_two_i,
  output logic                           fault_flag_one_o,
  output logic                           fault_flag_one_oe_n,
  output logic                           fault_flag_two_o,
  output logic                           fault_flag_two_oe_n,
  output logic [1:0]                     gate_hs,
  output logic [1:0]                     gate_ls
);
  import fbm_pkg::*;
  fbm_top_state_t          s_reg;
  fbm_top_state_t          s_next;
  fbm_ph_in_t [1:0]        ph_sync;
  fbm_sup_t                sup;
  fbm_ph_out_t [1:0]       pout;
  logic [15:0]             blank_cyc;
  logic                    allow;
  logic                    short_vis;
  logic [1:0]              short_hs_evt;
  logic [1:0]              short_ls_evt;
  logic                    boot_evt;
  logic                    addr_ph;

  // every pin input passes two flops before use
  fbm_sync #(
    .W       (19),
    .RST_VAL ({`FBM_PH_RST, `FBM_SUP_RST})
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({phase_pins, over_temp, gate_supply_uv, logic_supply_uv, short_threshold_input,
                reset_pin_n, fault_flag_one_i, fault_flag_two_i}),
    .q       ({ph_sync, sup})
  ); // [RL22] [RL7] [RL12]

  // blanking covers dead time and the comparator delay
  assign blank_cyc = {4'h0, s_reg.dead} + 16'(`FBM_BLANK_EXTRA_CYC); // [RL21]

  // visible short latch, hidden when detection is disabled
  assign short_vis = (|{s_reg.short_hs_lat, s_reg.short_ls_lat}) && !sup.short_off; // [RL15]

  // outputs stay off for any disabling fault, sleep or software hold
  assign allow = !(sup.gate_uv || sup.logic_uv || s_reg.boot_lat || short_vis
                   || s_reg.sleep || !s_reg.drive_en); // [RL3] [RL6] [RL11]

  // one sequencer per phase
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_phase
      fbm_phase u_phase (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .allow     (allow),
        .detect_en (!sup.short_off),
        .blank_cyc (blank_cyc),
        .pin       (ph_sync[gi]),
        .pout      (pout[gi])
      );
      assign short_hs_evt[gi] = pout[gi].short_hs;
      assign short_ls_evt[gi] = pout[gi].short_ls;
    end
  endgenerate

  assign boot_evt = pout[0].boot_fail || pout[1].boot_fail;
  assign addr_ph = hsel && htrans[1] && hready;

  // fault state, flags, reset pin timing and register slave
  always_comb begin
    logic clr_lat;
    logic lat_any;
    logic f1;
    logic f2;
    clr_lat = !sup.rst_pin_n;
    lat_any = 1'b0;
    f1 = 1'b0;
    f2 = 1'b0;
    s_next = s_reg;
    s_next.flag_o = 1'b0;
    s_next.hreadyout = 1'b1;
    // new events win over a reset-pin clear
    s_next.short_hs_lat = (clr_lat ? 2'b00 : s_reg.short_hs_lat) | short_hs_evt; // [RL14] [RL17] [RL19]
    s_next.short_ls_lat = (clr_lat ? 2'b00 : s_reg.short_ls_lat) | short_ls_evt; // [RL14] [RL16] [RL18]
    s_next.boot_lat = (s_reg.boot_lat && !clr_lat) || boot_evt; // [RL10] [RL19]
    // logic undervoltage replaces every other fault state
    if (sup.logic_uv) begin
      s_next.short_hs_lat = 2'b00; // [RL11]
      s_next.short_ls_lat = 2'b00;
      s_next.boot_lat = 1'b0;
    end
    // long low on the reset pin means sleep
    if (sup.rst_pin_n) begin
      s_next.res_cnt = '0;
      s_next.sleep = 1'b0;
    end else if (s_reg.res_cnt != 16'(`FBM_RES_LIMIT_CYC)) begin
      s_next.res_cnt = s_reg.res_cnt + 16'h0001;
    end else begin
      s_next.sleep = 1'b1; // [RL20]
    end
    lat_any = (|{s_next.short_hs_lat, s_next.short_ls_lat}) && !sup.short_off; // [RL15]
    // flags are the or of all active fault patterns
    f1 = sup.over_temp || sup.gate_uv || sup.logic_uv || s_next.boot_lat; // [RL2] [RL4] [RL6] [RL10]
    f2 = lat_any || sup.gate_uv || sup.logic_uv || s_next.boot_lat; // [RL2] [RL16] [RL17] [RL18]
    s_next.flag1_oe_n = f1; // [RL1] [RL23]
    s_next.flag2_oe_n = f2; // [RL1] [RL23]
    s_next.gate_hs = allow ? {pout[1].gate_hs, pout[0].gate_hs} : 2'b00; // [RL3]
    s_next.gate_ls = allow ? {pout[1].gate_ls, pout[0].gate_ls} : 2'b00; // [RL3]
    // write lands in the data phase after the address phase
    s_next.wr_pend = addr_ph && hwrite;
    if (addr_ph) begin
      s_next.addr = haddr[`FBM_ADDR_W-1:0];
    end
    if (s_reg.wr_pend) begin
      case (s_reg.addr)
        `FBM_ADDR_CTRL: s_next.drive_en = hwdata[`FBM_CTRL_EN_BIT];
        `FBM_ADDR_DEAD: s_next.dead = hwdata[`FBM_DEAD_W-1:0];
        default: s_next.drive_en = s_reg.drive_en;
      endcase
    end
    // read data captured at the address phase, unmapped reads zero
    if (addr_ph && !hwrite) begin
      case (haddr[`FBM_ADDR_W-1:0])
        `FBM_ADDR_CTRL: s_next.hrdata = {31'h0000_0000, s_reg.drive_en};
        `FBM_ADDR_DEAD: s_next.hrdata = {20'h0_0000, s_reg.dead};
        `FBM_ADDR_STAT: s_next.hrdata = {18'h0_0000, sup.flag2_pin, sup.flag1_pin,
                                        s_reg.short_ls_lat, s_reg.short_hs_lat, s_reg.sleep,
                                        s_reg.boot_lat, sup.short_off, sup.logic_uv, sup.gate_uv,
                                        sup.over_temp, s_reg.flag2_oe_n, s_reg.flag1_oe_n};
        default: s_next.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // all state in one register; flags raised from power-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.hreadyout <= 1'b1;
      s_reg.drive_en <= `FBM_CTRL_RST;
      s_reg.dead <= `FBM_DEAD_RST;
      s_reg.flag1_oe_n <= 1'b1; // [RL7] [RL12]
      s_reg.flag2_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ports straight from the state register; slave always answers okay
  assign hreadyout = s_reg.hreadyout;
  assign hrdata = s_reg.hrdata;
  assign hresp = s_reg.flag_o;
  assign fault_flag_one_o = s_reg.flag_o;
  assign fault_flag_two_o = s_reg.flag_o;
  assign fault_flag_one_oe_n = s_reg.flag1_oe_n;
  assign fault_flag_two_oe_n = s_reg.flag2_oe_n;
  assign gate_hs = s_reg.gate_hs;
  assign gate_ls = s_reg.gate_ls;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_luv_both_flags: assert property (sup.logic_uv |=> (s_reg.flag1_oe_n && s_reg.flag2_oe_n))
    else $error("logic undervoltage did not raise both flags"); // [RL11]
  a_luv_wipes_latch: assert property (sup.logic_uv |=> (s_reg.short_hs_lat == 2'b00 && !s_reg.boot_lat))
    else $error("logic undervoltage left a latched fault"); // [RL11]
  a_guv_gates_off: assert property (sup.gate_uv |=> (gate_hs == 2'b00 && gate_ls == 2'b00))
    else $error("gate drive on during gate undervoltage"); // [RL6]
  a_ot_flag_one: assert property ((sup.over_temp && !sup.gate_uv && !sup.logic_uv) |=> s_reg.flag1_oe_n)
    else $error("overtemperature did not raise flag one"); // [RL4]
  a_flag_pull_low: assert property (!s_reg.flag1_oe_n |-> (!$past(sup.over_temp) && !$past(sup.gate_uv)))
    else $error("flag one pulled low during a fault"); // [RL23]
  a_short_latches: assert property ((|short_hs_evt && !sup.logic_uv && !sup.short_off) |=> s_reg.flag2_oe_n)
    else $error("short event did not raise flag two"); // [RL14]
  a_short_hidden: assert property ((sup.short_off && !sup.gate_uv && !sup.logic_uv && !boot_evt
    && !s_reg.boot_lat) |=> !s_reg.flag2_oe_n) else $error("short shown while detection off"); // [RL15]
  a_pulse_clears: assert property ((!sup.rst_pin_n && !boot_evt && !(|short_hs_evt) && !(|short_ls_evt))
    |=> (!s_reg.boot_lat && s_reg.short_ls_lat == 2'b00)) else $error("reset pin left a latched fault"); // [RL19]
  a_sleep_entry: assert property ((!sup.rst_pin_n && s_reg.res_cnt == 16'(`FBM_RES_LIMIT_CYC)) |=> s_reg.sleep)
    else $error("sustained reset did not enter sleep"); // [RL20]
  // a reset pin low or logic undervoltage may legally drop the latch
  a_boot_latch: assert property ((boot_evt && !sup.logic_uv) |=> s_reg.boot_lat) // [RL10]
    else $error("bootstrap fault not latched");
  a_boot_hold: assert property ((s_reg.boot_lat && sup.rst_pin_n && !sup.logic_uv) |=> s_reg.boot_lat) // [RL10]
    else $error("bootstrap fault not held");

  c_boot_fault: cover property (boot_evt);
  c_short_hs: cover property (|short_hs_evt);
  c_sleep: cover property (s_reg.sleep);
  c_ahb_read: cover property (addr_ph && !hwrite);
endmodule : fbm_fault_monitor

// File: fbm_fault_monitor_bench.sv
// self-checking bench for the bridge fault monitor
`timescale 1ns/10ps
`include "fbm_consts.svh"
module fbm_fault_monitor_bench;
  import fbm_pkg::*;
  logic             hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0]      haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]       htrans = '0, hs_req = '0, ls_req = 2'b01, sh_hs = '0, sh_ls = '0, cap_bad = '0;
  logic             otemp = 0, guv = 1, luv = 1, sdis = 0, rpin = 1;
  logic             hreadyout, hresp, o1, o2, oe1, oe2, p1, p2;
  logic [1:0]       gate_hs, gate_ls, bok, blow, vh, vl;
  fbm_ph_in_t [1:0] pins;
  int               bad_count = 0, check_count = 0;

  always #2.5 hclk = ~hclk;
  assign pins[0] = {hs_req[0], ls_req[0], bok[0], blow[0], vh[0], vl[0]};
  assign pins[1] = {hs_req[1], ls_req[1], bok[1], blow[1], vh[1], vl[1]};

  fbm_fault_monitor fbm_fault_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .phase_pins(pins), .over_temp(otemp),
    .gate_supply_uv(guv), .logic_supply_uv(luv), .short_threshold_input(sdis), .reset_pin_n(rpin),
    .fault_flag_one_i(p1), .fault_flag_two_i(p2), .fault_flag_one_o(o1), .fault_flag_one_oe_n(oe1),
    .fault_flag_two_o(o2), .fault_flag_two_oe_n(oe2), .gate_hs(gate_hs), .gate_ls(gate_ls));

  fbm_bridge_model fbm_bridge_model_inst (.clk(hclk), .gate_hs(gate_hs), .gate_ls(gate_ls),
    .short_hs(sh_hs), .short_ls(sh_ls), .cap_bad(cap_bad), .f1_o(o1), .f1_oe_n(oe1), .f2_o(o2),
    .f2_oe_n(oe2), .boot_ok(bok), .boot_low(blow), .vds_hs(vh), .vds_ls(vl), .f1_pin(p1), .f2_pin(p2));

  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for a flag pair; pins and drive levels checked with it
  task wait_fl(input logic [1:0] e, input int n);
    int i;
    for (i = 0; i < n && {oe1, oe2} !== e; i++) @(posedge hclk);
    chk({oe1, oe2, p1, p2, o1, o2}, {e, e, 2'b00});
    if ({oe1, oe2} !== e) results;
  endtask : wait_fl

  task wait_g(input logic [3:0] e, input int n);
    int i;
    for (i = 0; i < n && {gate_hs, gate_ls} !== e; i++) @(posedge hclk);
    chk({gate_hs, gate_ls}, e);
    if ({gate_hs, gate_ls} !== e) results;
  endtask : wait_g

  // flags must not move for n cycles
  task hold_fl(input logic [1:0] e, input int n);
    int i;
    for (i = 0; i < n && {oe1, oe2} === e; i++) @(posedge hclk);
    chk(i, n);
  endtask : hold_fl

  // one single ahb-lite transfer; ready is sampled at each edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    int i;
    i = 0;
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 40);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 80);
    r = hrdata;
    chk(hresp, 0);
    // a bus that never answers is a mismatch, not a quiet end
    if (i >= 40) begin
      chk(0, 1);
      results;
    end
  endtask : ahb

  task t_power;
    hold_fl(2'b11, 20);
    chk({gate_hs, gate_ls}, 0);
    guv <= 1'b0;
    hold_fl(2'b11, 20);
    luv <= 1'b0;
    wait_fl(2'b00, 10);
    wait_g(4'b0001, 10);
  endtask : t_power

  task t_regs;
    ahb(0, `FBM_ADDR_CTRL, 0, rd); chk(rd, 1);
    ahb(0, `FBM_ADDR_DEAD, 0, rd); chk(rd, 32'h0000_0028);
    ahb(1, `FBM_ADDR_DEAD, 32'h0000_0008, rd);
    ahb(0, `FBM_ADDR_DEAD, 0, rd); chk(rd, 32'h0000_0008);
    ahb(0, `FBM_ADDR_STAT, 0, rd); chk(rd, 0);
    ahb(0, 8'h0c, 0, rd); chk(rd, 0);
    ahb(1, `FBM_ADDR_CTRL, 0, rd);
    wait_g(4'b0000, 5);
    ahb(1, `FBM_ADDR_CTRL, 1, rd);
    wait_g(4'b0001, 5);
  endtask : t_regs

  // host would throttle on this flag; drive is kept on to show nothing stops
  task t_heat;
    otemp <= 1'b1;
    wait_fl(2'b10, 10);
    hold_fl(2'b10, 10);
    chk({gate_hs, gate_ls}, 4'b0001);
    guv <= 1'b1;
    wait_fl(2'b11, 10);
    wait_g(4'b0000, 5);
    otemp <= 1'b0;
    guv <= 1'b0;
    wait_fl(2'b00, 10);
    wait_g(4'b0001, 10);
  endtask : t_heat

  task t_boot;
    hs_req[1] <= 1'b1;
    wait_g(4'b0011, 10);
    wait_g(4'b1001, 80);
    cap_bad[1] <= 1'b1;
    wait_g(4'b0011, 20);
    wait_fl(2'b11, 2100);
    wait_g(4'b0000, 5);
    cap_bad[1] <= 1'b0;
    hs_req[1] <= 1'b0;
    ls_req[0] <= 1'b0;
    hold_fl(2'b11, 50);
    rpin <= 1'b0;
    repeat (20) @(posedge hclk);
    rpin <= 1'b1;
    wait_fl(2'b00, 20);
  endtask : t_boot

  // short on phase 0, low side or high side, from a clean turn-on
  task t_fet(input logic hs);
    if (hs) begin sh_hs[0] <= 1'b1; hs_req[0] <= 1'b1; end
    else begin sh_ls[0] <= 1'b1; ls_req[0] <= 1'b1; end
    wait_g(hs ? 4'b0100 : 4'b0001, 20);
    hold_fl(2'b00, 100);
    wait_fl(2'b01, 80);
    wait_g(4'b0000, 5);
  endtask : t_fet

  task t_short;
    t_fet(1'b0);
    sdis <= 1'b1;
    wait_fl(2'b00, 10);
    sdis <= 1'b0;
    wait_fl(2'b01, 10);
    ls_req[0] <= 1'b0;
    sh_ls[0] <= 1'b0;
    luv <= 1'b1;
    wait_fl(2'b11, 10);
    luv <= 1'b0;
    wait_fl(2'b00, 10);
    t_fet(1'b1);
    rpin <= 1'b0;
    repeat (2100) @(posedge hclk);
    ahb(0, `FBM_ADDR_STAT, 0, rd); chk(rd, 32'h0000_0080);
    hs_req[0] <= 1'b0;
    sh_hs[0] <= 1'b0;
    rpin <= 1'b1;
    wait_fl(2'b00, 20);
  endtask : t_short

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_power;
    t_regs;
    t_heat;
    t_boot;
    t_short;
    results;
  end

  // watchdog against a hang anywhere
  initial begin
    repeat (60000) @(posedge hclk);
    chk(0, 1);
    results;
  end
endmodule : fbm_fault_monitor_bench

// File: fbm_phase.sv
// one bridge phase: bootstrap sequencing, blanking and short detection
`timescale 1ns/10ps
`include "fbm_consts.svh"
module fbm_phase (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                allow,
  input  wire logic                detect_en,
  input  wire logic [15:0]         blank_cyc,
  input  wire fbm_pkg::fbm_ph_in_t pin,
  output fbm_pkg::fbm_ph_out_t     pout
);
  import fbm_pkg::*;
  fbm_ph_state_t s_reg;
  fbm_ph_state_t s_next;

  // drive sequencing plus per-fet blanking counters
  always_comb begin
    s_next = s_reg;
    s_next.out.short_hs = 1'b0;
    s_next.out.short_ls = 1'b0;
    s_next.out.boot_fail = 1'b0;
    case (s_reg.st)
      PH_OFF: begin
        s_next.tmo_cnt = '0;
        if (pin.hs_req) begin
          s_next.st = pin.boot_ok ? PH_HS_ON : PH_CHARGE; // [RL8]
        end else if (pin.ls_req) begin
          s_next.st = PH_LS_ON;
        end
      end
      PH_CHARGE: begin
        s_next.tmo_cnt = s_reg.tmo_cnt + 16'h0001;
        if (pin.boot_ok) begin
          s_next.st = pin.hs_req ? PH_HS_ON : PH_OFF; // [RL8]
        end else if (s_reg.tmo_cnt == 16'(`FBM_BOOT_TMO_CYC - 1)) begin
          s_next.out.boot_fail = 1'b1; // [RL10]
          s_next.st = PH_OFF;
        end
      end
      PH_HS_ON: begin
        if (!pin.hs_req) begin
          s_next.st = PH_OFF;
        end else if (pin.boot_low) begin
          s_next.st = PH_CHARGE; // [RL9]
          s_next.tmo_cnt = '0;
        end
      end
      PH_LS_ON: begin
        if (!pin.ls_req) begin
          s_next.st = PH_OFF;
        end
      end
      default: s_next.st = PH_OFF;
    endcase
    // a disabling fault overrides everything, even a charge cycle
    if (!allow) begin
      s_next.st = PH_OFF; // [RL3]
      s_next.tmo_cnt = '0;
    end
    s_next.out.gate_hs = (s_next.st == PH_HS_ON);
    s_next.out.gate_ls = (s_next.st == PH_LS_ON) || (s_next.st == PH_CHARGE);
    // comparator ignored while off and until blanking ends
    if (!s_reg.out.gate_hs) begin
      s_next.blk_hs = '0; // [RL13]
    end else if (s_reg.blk_hs < blank_cyc) begin
      s_next.blk_hs = s_reg.blk_hs + 16'h0001;
    end else begin
      s_next.out.short_hs = pin.vds_hs && detect_en; // [RL14] [RL17]
    end
    if (!s_reg.out.gate_ls) begin
      s_next.blk_ls = '0; // [RL13]
    end else if (s_reg.blk_ls < blank_cyc) begin
      s_next.blk_ls = s_reg.blk_ls + 16'h0001;
    end else begin
      s_next.out.short_ls = pin.vds_ls && detect_en; // [RL14] [RL16]
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pout = s_reg.out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_charge_before_hs: assert property ((s_reg.st == PH_OFF && pin.hs_req && !pin.boot_ok && allow)
    |=> (s_reg.out.gate_ls && !s_reg.out.gate_hs)) else $error("no charge cycle before high side"); // [RL8]
  a_hs_sag_recharge: assert property ((s_reg.st == PH_HS_ON && pin.hs_req && pin.boot_low && allow)
    |=> (s_reg.st == PH_CHARGE && !s_reg.out.gate_hs)) else $error("sagging bootstrap not recharged"); // [RL9]
  a_off_no_short: assert property (!s_reg.out.gate_hs |=> !s_reg.out.short_hs)
    else $error("short flagged on an off fet"); // [RL13]
endmodule : fbm_phase

// File: fbm_pkg.sv
// types shared by the bridge fault monitor modules
package fbm_pkg;
  typedef enum logic [1:0] {
    PH_OFF    = 2'b00,
    PH_CHARGE = 2'b01,
    PH_HS_ON  = 2'b10,
    PH_LS_ON  = 2'b11
  } fbm_ph_mode_t;

  // per-phase pin inputs after synchronisation
  typedef struct packed {
    logic hs_req;
    logic ls_req;
    logic boot_ok;
    logic boot_low;
    logic vds_hs;
    logic vds_ls;
  } fbm_ph_in_t;

  typedef struct packed {
    logic gate_hs;
    logic gate_ls;
    logic short_hs;
    logic short_ls;
    logic boot_fail;
  } fbm_ph_out_t;

  // supply, temperature, reset pin and flag readback
  typedef struct packed {
    logic over_temp;
    logic gate_uv;
    logic logic_uv;
    logic short_off;
    logic rst_pin_n;
    logic flag1_pin;
    logic flag2_pin;
  } fbm_sup_t;

  typedef struct packed {
    fbm_ph_mode_t st;
    logic [15:0]  tmo_cnt;
    logic [15:0]  blk_hs;
    logic [15:0]  blk_ls;
    fbm_ph_out_t  out;
  } fbm_ph_state_t;

  typedef struct packed {
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        wr_pend;
    logic [7:0]  addr;
    logic        drive_en;
    logic [11:0] dead;
    logic [1:0]  short_hs_lat;
    logic [1:0]  short_ls_lat;
    logic        boot_lat;
    logic [15:0] res_cnt;
    logic        sleep;
    logic [1:0]  gate_hs;
    logic [1:0]  gate_ls;
    logic        flag1_oe_n;
    logic        flag2_oe_n;
    logic        flag_o;
  } fbm_top_state_t;
endpackage : fbm_pkg

// File: fbm_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module fbm_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } fbm_sync_state_t;
  fbm_sync_state_t s_reg;
  fbm_sync_state_t s_next;

  // first stage is read only by the second
  always_comb begin
    s_next.meta = d;
    s_next.stab = s_reg.meta;
  end

  // reset value lets supply monitors start in fault
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= {RST_VAL, RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stab;
endmodule : fbm_sync
